// *** rtl/dma_channel_pkg.sv ***
// constants, field layout and states of the dma channel control block
//
// Summary of operation
// - software enable write runs direct mode
// - enable fetched from descriptor runs list mode
// - loop set leaves descriptor unmodified at close
// - size field selects byte, word or quad
// - destination step: fixed, increment, decrement
// - source step: fixed, increment, decrement
// - buffer-end enable raises interrupt at completion
// - list mode, no jump: pointer plus 16
// - list mode, jump: pointer loads descriptor address
// - frame-end bit marks last buffer of frame
// - list mode halt bit stops after buffer
// - first transfer drives nibble with valid strobe
// - frame end requests peripheral status into nibble
// - list mode writes nibble back to descriptor
// - nibble passed through unchanged, meaning is opaque
// - list pointer low byte write starts list mode
// - early peripheral end of frame raises interrupt
// - after pointer update fetch next descriptor
package dma_channel_pkg;

   // =========================================================
   // register byte addresses
   localparam logic [23:0] ADDR_CTRL   = 24'hffe410;
   localparam logic [23:0] ADDR_LEN    = 24'hffe460;
   localparam logic [23:0] ADDR_SRC    = 24'hffe464;
   localparam logic [23:0] ADDR_DST    = 24'hffe468;
   localparam logic [23:0] ADDR_LIST   = 24'hffe46c;
   localparam logic [23:0] ADDR_STAT   = 24'hffe470;
   localparam logic [23:0] ADDR_MASK   = 24'hffe474;
   localparam logic [23:0] ADDR_STATE  = 24'hffe478;

   // =========================================================
   // control word fields
   localparam int CTL_EN     = 15;
   localparam int CTL_LOOP   = 14;
   localparam int CTL_SIZE   = 12;
   localparam int CTL_DST    = 10;
   localparam int CTL_SRC    = 8;
   localparam int CTL_BUFFER_END_IRQ_ENABLE   = 7;
   localparam int CTL_JUMP   = 6;
   localparam int CTL_EOF    = 5;
   localparam int CTL_HALT   = 4;
   localparam int CTL_CMD    = 0;

   // step and size codes
   localparam logic [1:0] STEP_FIXED = 2'h0;
   localparam logic [1:0] STEP_INC   = 2'h1;
   localparam logic [1:0] STEP_DEC   = 2'h2;
   localparam logic [1:0] CODE_RSVD  = 2'h3;

   // interrupt status bits
   localparam int IRQ_BUF_END = 0;
   localparam int IRQ_EARLY   = 1;
   localparam int IRQ_REFUSED = 2;

   // reset values and list stride
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam logic [2:0]  IRQ_RESET  = 3'h0;
   localparam logic [23:0] LIST_STEP  = 24'h000010;

   // channel sequence
   typedef enum logic [2:0] {
      S_IDLE, S_FETCH, S_FIRST, S_XFER,
      S_END, S_STAT, S_CLOSE, S_NEWLIST
   } chan_state_t;

endpackage : dma_channel_pkg

// *** rtl/dma_channel_control.sv ***
// control word and sequencing of one dma channel with apb registers
`timescale 1ns/1ps
`default_nettype none
module dma_channel_control
   import dma_channel_pkg::*;
(
   input  wire logic        CLOCK,
   input  wire logic        RST,
   // apb slave
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [23:0] PADDR,
   input  wire logic [31:0] PWDATA,
   input  wire logic [3:0]  PSTRB,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   output logic             IRQ,
   // descriptor memory
   output logic             DESC_REQ,
   output logic      [23:0] DESC_ADDR,
   input  wire logic        DESC_ACK,
   input  wire logic [15:0] DESC_CTRL,
   input  wire logic [15:0] DESC_LEN,
   input  wire logic [23:0] DESC_SRC,
   input  wire logic [23:0] DESC_DST,
   input  wire logic [23:0] DESC_NEXT,
   output logic             DESC_WB,
   output logic      [15:0] DESC_WB_WORD,
   // data mover
   output logic             XFER_REQ,
   output logic      [23:0] XFER_SRC,
   output logic      [23:0] XFER_DST,
   output logic      [1:0]  XFER_SIZE,
   input  wire logic        XFER_ACK,
   // peripheral command bus
   output logic      [3:0]  CMD_BUS,
   output logic             CMD_VALID,
   input  wire logic        PERIPH_EOF,
   output logic             STAT_REQ,
   input  wire logic        STAT_ACK,
   input  wire logic [3:0]  STAT_DATA
);

   // =========================================================
   // helper functions
   // reserved size or step codes refuse the buffer
   function automatic logic is_legal(input logic [15:0] c);
      is_legal = (c[CTL_SIZE+:2] != CODE_RSVD) &&
                 (c[CTL_DST+:2]  != CODE_RSVD) &&
                 (c[CTL_SRC+:2]  != CODE_RSVD);
   endfunction : is_legal

   // next address for a step code and unit size
   function automatic logic [23:0] step_addr(input logic [23:0] a,
                                             input logic [1:0]  mode,
                                             input logic [1:0]  size);
      logic [23:0] unit;
      unit = 24'h000001 << size;
      case (mode)
         STEP_INC: step_addr = a + unit;
         STEP_DEC: step_addr = a - unit;
         default:  step_addr = a;
      endcase
   endfunction : step_addr

   // byte-lane merge of an apb write
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0]  st);
      logic [31:0] m;
      m = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}};
      merge = (old & ~m) | (wd & m);
   endfunction : merge

   // =========================================================
   // state
   chan_state_t state_ff;             // channel sequence
   chan_state_t nxt_state;            // next sequence step
   logic [15:0] ctrl_ff;              // control word
   logic [15:0] len_ff;               // remaining units
   logic [23:0] src_ff;               // source pointer
   logic [23:0] dst_ff;               // destination pointer
   logic [23:0] list_ff;              // list pointer
   logic [23:0] next_list_ff;         // jump target from descriptor
   logic        linked_ff;            // list mode flag
   logic        early_ff;             // buffer cut by peripheral
   logic [2:0]  irq_stat_ff;          // sticky events
   logic [2:0]  irq_mask_ff;          // event enables
   logic        pready_ff;            // access phase answer
   logic        pslverr_ff;           // unmapped address
   logic [31:0] prdata_ff;            // read data
   logic        irq_ff;               // interrupt line
   logic        desc_wb_ff;           // writeback pulse
   logic [15:0] wb_word_ff;           // writeback word
   logic        cmd_valid_ff;         // first transfer strobe
   logic        xfer_req_ff;          // transfer request
   logic        desc_req_ff;          // descriptor fetch request
   logic        stat_req_ff;          // status request

   // =========================================================
   // apb decode
   wire setup_ph  = PSEL && !PENABLE;
   wire access_ph = PSEL && PENABLE && pready_ff;
   wire wr        = access_ph && PWRITE;
   wire hit_ctrl  = PADDR == ADDR_CTRL;
   wire hit_len   = PADDR == ADDR_LEN;
   wire hit_src   = PADDR == ADDR_SRC;
   wire hit_dst   = PADDR == ADDR_DST;
   wire hit_list  = PADDR == ADDR_LIST;
   wire hit_stat  = PADDR == ADDR_STAT;
   wire hit_mask  = PADDR == ADDR_MASK;
   wire hit_state = PADDR == ADDR_STATE;
   wire mapped    = hit_ctrl | hit_len | hit_src | hit_dst | hit_list |
                    hit_stat | hit_mask | hit_state;
   wire wr_ctrl   = wr && hit_ctrl;
   wire wr_len    = wr && hit_len;
   wire wr_src    = wr && hit_src;
   wire wr_dst    = wr && hit_dst;
   wire wr_list   = wr && hit_list;
   wire [31:0] ctrl_wd = merge({16'h0000, ctrl_ff}, PWDATA, PSTRB);
   wire [31:0] len_wd  = merge({16'h0000, len_ff}, PWDATA, PSTRB);
   wire [31:0] src_wd  = merge({8'h00, src_ff}, PWDATA, PSTRB);
   wire [31:0] dst_wd  = merge({8'h00, dst_ff}, PWDATA, PSTRB);
   wire [31:0] list_wd = merge({8'h00, list_ff}, PWDATA, PSTRB);

   // =========================================================
   // start, stop and transfer decode
   wire idle        = state_ff == S_IDLE;
   wire sw_enable   = wr_ctrl && ctrl_wd[CTL_EN];
   wire start_dir   = idle && sw_enable && is_legal(ctrl_wd[15:0]);
   // low byte of list pointer starts list mode
   wire start_list  = idle && wr_list && PSTRB[0];
   wire sw_stop     = wr_ctrl && !ctrl_wd[CTL_EN] && !idle;
   wire moving      = state_ff == S_FIRST || state_ff == S_XFER;
   wire unit_done   = moving && XFER_ACK;
   wire last_unit   = len_ff == 16'h0001;
   wire cut_short   = moving && PERIPH_EOF && !XFER_ACK;
   // fetched enable keeps list mode running
   wire fetch_ok    = state_ff == S_FETCH && DESC_ACK &&
                      DESC_CTRL[CTL_EN] && is_legal(DESC_CTRL);
   wire refused     = (idle && sw_enable && !is_legal(ctrl_wd[15:0])) ||
                      (state_ff == S_FETCH && DESC_ACK &&
                       DESC_CTRL[CTL_EN] && !is_legal(DESC_CTRL));
   wire closing     = state_ff == S_CLOSE;
   wire stops_here  = closing && (!linked_ff || ctrl_ff[CTL_HALT]);
   wire stat_take   = state_ff == S_STAT && STAT_ACK;
   wire [2:0] irq_set;
   wire [2:0] irq_clr = (wr && hit_stat && PSTRB[0]) ? PWDATA[2:0] : 3'h0;

   // buffer end raises interrupt only when enabled
   assign irq_set[IRQ_BUF_END] = closing && ctrl_ff[CTL_BUFFER_END_IRQ_ENABLE];
   // early end of frame always interrupts
   assign irq_set[IRQ_EARLY]   = closing && early_ff;
   assign irq_set[IRQ_REFUSED] = refused;

   // =========================================================
   // sequence next state
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         S_IDLE: begin
            if (start_dir) begin
               nxt_state = S_FIRST;
            end else if (start_list) begin
               nxt_state = S_FETCH;
            end
         end
         S_FETCH: begin
            if (DESC_ACK) begin
               nxt_state = fetch_ok ? S_FIRST : S_IDLE;
            end
         end
         S_FIRST, S_XFER: begin
            if (unit_done && last_unit) begin
               nxt_state = S_END;
            end else if (cut_short) begin
               nxt_state = S_END;
            end else if (unit_done) begin
               nxt_state = S_XFER;
            end
         end
         S_END: begin
            // frame end marks last buffer, status follows
            nxt_state = ctrl_ff[CTL_EOF] ? S_STAT : S_CLOSE;
         end
         S_STAT: begin
            if (STAT_ACK) begin
               nxt_state = S_CLOSE;
            end
         end
         S_CLOSE: begin
            nxt_state = stops_here ? S_IDLE : S_NEWLIST;
         end
         S_NEWLIST: begin
            nxt_state = S_FETCH;
         end
         default: nxt_state = S_IDLE;
      endcase
      // software disable wins over any step
      if (sw_stop) begin
         nxt_state = S_IDLE;
      end
   end

   // =========================================================
   // sequence register and mode flags
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         state_ff  <= S_IDLE;
         linked_ff <= 1'b0;
         early_ff  <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         if (start_dir) begin
            linked_ff <= 1'b0;
         end else if (start_list || fetch_ok) begin
            linked_ff <= 1'b1;
         end
         // remember a cut buffer until close
         if (cut_short) begin
            early_ff <= 1'b1;
         end else if (closing || idle) begin
            early_ff <= 1'b0;
         end
      end
   end

   // =========================================================
   // control word: software, descriptor and status writes
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         ctrl_ff <= CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl_ff <= ctrl_wd[15:0];
      end else if (fetch_ok) begin
         ctrl_ff <= DESC_CTRL;
      end else if (stat_take) begin
         // peripheral status lands in the nibble
         ctrl_ff[CTL_CMD+:4] <= STAT_DATA;
      end else if (stops_here || (state_ff == S_FETCH && DESC_ACK &&
                                  !fetch_ok)) begin
         ctrl_ff[CTL_EN] <= 1'b0;
      end
   end

   // =========================================================
   // length and address pointers
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         len_ff <= 16'h0000;
         src_ff <= 24'h000000;
         dst_ff <= 24'h000000;
      end else if (fetch_ok) begin
         len_ff <= DESC_LEN;
         src_ff <= DESC_SRC;
         dst_ff <= DESC_DST;
      end else if (unit_done) begin
         len_ff <= len_ff - 16'h0001;
         src_ff <= step_addr(src_ff, ctrl_ff[CTL_SRC+:2],
                             ctrl_ff[CTL_SIZE+:2]);
         dst_ff <= step_addr(dst_ff, ctrl_ff[CTL_DST+:2],
                             ctrl_ff[CTL_SIZE+:2]);
      end else begin
         if (wr_len) len_ff <= len_wd[15:0];
         if (wr_src) src_ff <= src_wd[23:0];
         if (wr_dst) dst_ff <= dst_wd[23:0];
      end
   end

   // list pointer and jump target
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         list_ff      <= 24'h000000;
         next_list_ff <= 24'h000000;
      end else begin
         if (fetch_ok) begin
            next_list_ff <= DESC_NEXT;
         end
         if (wr_list) begin
            list_ff <= list_wd[23:0];
         end else if (state_ff == S_NEWLIST) begin
            list_ff <= ctrl_ff[CTL_JUMP] ? next_list_ff
                                         : list_ff + LIST_STEP;
         end
      end
   end

   // =========================================================
   // interrupt status, mask and line
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         irq_stat_ff <= IRQ_RESET;
         irq_mask_ff <= IRQ_RESET;
         irq_ff      <= 1'b0;
      end else begin
         // a new event beats a clear in the same cycle
         irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
         if (wr && hit_mask && PSTRB[0]) begin
            irq_mask_ff <= PWDATA[2:0];
         end
         irq_ff <= |(irq_stat_ff & irq_mask_ff);
      end
   end

   // =========================================================
   // apb answer, one wait-free access phase
   wire [31:0] rd_mux =
      hit_ctrl  ? {16'h0000, ctrl_ff} :
      hit_len   ? {16'h0000, len_ff}  :
      hit_src   ? {8'h00, src_ff}     :
      hit_dst   ? {8'h00, dst_ff}     :
      hit_list  ? {8'h00, list_ff}    :
      hit_stat  ? {29'h0, irq_stat_ff} :
      hit_mask  ? {29'h0, irq_mask_ff} :
      hit_state ? {28'h0, linked_ff, state_ff} : 32'h00000000;

   always_ff @(posedge CLOCK) begin
      if (RST) begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= 32'h00000000;
      end else begin
         pready_ff  <= setup_ph;
         pslverr_ff <= setup_ph && !mapped;
         prdata_ff  <= (setup_ph && !PWRITE) ? rd_mux : 32'h00000000;
      end
   end

   // =========================================================
   // link side requests follow the next state; write-back pulse follows close
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         xfer_req_ff  <= 1'b0;
         cmd_valid_ff <= 1'b0;
         desc_req_ff  <= 1'b0;
         stat_req_ff  <= 1'b0;
         desc_wb_ff   <= 1'b0;
         wb_word_ff   <= 16'h0000;
      end else begin
         xfer_req_ff  <= nxt_state == S_FIRST || nxt_state == S_XFER;
         // strobe rides with the first unit
         cmd_valid_ff <= nxt_state == S_FIRST;
         desc_req_ff  <= nxt_state == S_FETCH;
         stat_req_ff  <= nxt_state == S_STAT;
         desc_wb_ff   <= closing && linked_ff && !ctrl_ff[CTL_LOOP];
         if (closing) begin
            wb_word_ff <= ctrl_ff;
         end
      end
   end

   // =========================================================
   // outputs
   assign PRDATA       = prdata_ff;
   assign PREADY       = pready_ff;
   assign PSLVERR      = pslverr_ff;
   assign IRQ          = irq_ff;
   assign DESC_REQ     = desc_req_ff;
   assign DESC_ADDR    = list_ff;
   assign DESC_WB      = desc_wb_ff;
   assign DESC_WB_WORD = wb_word_ff;
   assign XFER_REQ     = xfer_req_ff;
   assign XFER_SRC     = src_ff;
   assign XFER_DST     = dst_ff;
   // unit size straight from the field
   assign XFER_SIZE    = ctrl_ff[CTL_SIZE+:2];
   assign CMD_BUS      = ctrl_ff[CTL_CMD+:4];
   assign CMD_VALID    = cmd_valid_ff;
   assign STAT_REQ     = stat_req_ff;

   // =========================================================
   // checks
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (RST);

   chk_cmd_first_xfer: assert property (
      CMD_VALID |-> XFER_REQ && state_ff == S_FIRST)
      else $error("command strobe without first transfer");
   chk_src_step_inc: assert property (
      unit_done && !fetch_ok && ctrl_ff[CTL_SRC+:2] == STEP_INC
      |=> XFER_SRC == $past(src_ff) + (24'h000001 << $past(XFER_SIZE)))
      else $error("source did not increment by unit");
   chk_dst_step_dec: assert property (
      unit_done && !fetch_ok && ctrl_ff[CTL_DST+:2] == STEP_DEC
      |=> XFER_DST == $past(dst_ff) - (24'h000001 << $past(XFER_SIZE)))
      else $error("destination did not decrement by unit");
   chk_list_advance: assert property (
      state_ff == S_NEWLIST && !ctrl_ff[CTL_JUMP] && !wr_list
      |=> list_ff == $past(list_ff) + 24'h000010)
      else $error("list pointer did not advance by 16");
   chk_list_jump: assert property (
      state_ff == S_NEWLIST && ctrl_ff[CTL_JUMP] && !wr_list
      |=> list_ff == $past(next_list_ff))
      else $error("list pointer did not load jump target");
   chk_refetch_after: assert property (
      state_ff == S_NEWLIST && !sw_stop |=> DESC_REQ && state_ff == S_FETCH)
      else $error("no fetch after list update");
   chk_loop_no_wb: assert property (
      closing && ctrl_ff[CTL_LOOP] |=> !DESC_WB)
      else $error("descriptor written back in loop mode");
   chk_buffer_end_irq_enable_sets: assert property (
      closing && ctrl_ff[CTL_BUFFER_END_IRQ_ENABLE] |=> irq_stat_ff[IRQ_BUF_END])
      else $error("buffer end event lost");
   chk_reserved_idle: assert property (
      XFER_REQ |-> is_legal(ctrl_ff))
      else $error("transfer running on reserved code");
   chk_status_store: assert property (
      stat_take && !wr_ctrl |=> CMD_BUS == $past(STAT_DATA))
      else $error("peripheral status not stored");
   chk_halt_stops: assert property (
      closing && linked_ff && ctrl_ff[CTL_HALT] |=> idle ##1 !DESC_REQ)
      else $error("halt did not stop the list");

   cov_direct_done: cover property (
      closing && !linked_ff ##1 idle);
   cov_list_next: cover property (
      state_ff == S_NEWLIST ##1 state_ff == S_FETCH);
   cov_status_req: cover property (STAT_REQ ##[1:20] STAT_ACK);
   cov_early_cut: cover property (cut_short ##[1:10] irq_ff);

endmodule : dma_channel_control
`default_nettype wire

// *** sim/periph_model.sv ***
// far-side model: descriptor memory, data mover and peripheral status
`timescale 1ns/1ps
`default_nettype none
module periph_model (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       slow,      // stretch every answer
   input  wire logic       desc_req,
   output logic            desc_ack,
   input  wire logic       xfer_req,
   output logic            xfer_ack,
   input  wire logic       stat_req,
   output logic            stat_ack,
   output logic      [3:0] stat_data,
   input  wire logic [3:0] stat_val   // status handed back at frame end
);
   logic [1:0] wait_ff;               // answer delay counter
   wire        busy = desc_ack | xfer_ack | stat_ack;
   // ==========================================================
   // answers
   // never two acks in a row: the request falls one cycle late
   always_ff @(posedge clk) begin
      if (rst) begin
         {desc_ack, xfer_ack, stat_ack} <= 3'h0;
         stat_data <= 4'h0;
         wait_ff <= 2'h0;
      end else begin
         {desc_ack, xfer_ack, stat_ack} <= 3'h0;
         stat_data <= ~stat_data;     // released: toggles
         if ((desc_req | xfer_req | stat_req) & !busy) begin
            if (slow & (wait_ff != 2'h2)) begin
               wait_ff <= wait_ff + 2'h1;
            end else begin
               wait_ff <= 2'h0;
               desc_ack <= desc_req;
               xfer_ack <= xfer_req & !desc_req;
               stat_ack <= stat_req;
               if (stat_req) stat_data <= stat_val;
            end
         end
      end
   end
endmodule : periph_model
`default_nettype wire

// *** sim/tb.sv ***
// self-checking bench of the dma channel control block
`timescale 1ns/1ps
`default_nettype none
module tb;
   import dma_channel_pkg::*;
   logic CLOCK = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
   logic [23:0] PADDR = 0, XFER_SRC, XFER_DST, DESC_ADDR, src;
   logic [31:0] PWDATA = 0, PRDATA, rdv;
   logic [3:0] PSTRB = 4'hf, CMD_BUS, STAT_DATA, cmd, cmd_seen, stat_val = 0;
   logic [1:0] XFER_SIZE, sz, ds, ss, sz_seen, nd = 0;
   logic PREADY, PSLVERR, IRQ, DESC_REQ, DESC_ACK, DESC_WB, XFER_REQ, err;
   logic XFER_ACK, CMD_VALID, PERIPH_EOF = 0, STAT_REQ, STAT_ACK, slow = 0;
   logic [15:0] DESC_WB_WORD, DESC_CTRL;
   wire  [15:0] DESC_LEN = 16'h0001;
   wire  [23:0] DESC_SRC = 24'h004000;
   wire  [23:0] DESC_DST = 24'h005000;
   wire  [23:0] DESC_NEXT = 24'h003000;
   logic [15:0] dtab[4] = '{16'h8525, 16'h854a, 16'hc513, 16'h0000};
   logic [23:0] srcs[$], dsts[$], daq[$];
   logic [15:0] wbq[$];
   int mismatches = 0, checks = 0;
   assign DESC_CTRL = dtab[nd];       // next descriptor by fetch count
   always #2.5 CLOCK = ~CLOCK;
   dma_channel_control dut (.CLOCK(CLOCK), .RST(RST), .PSEL(PSEL),
      .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
      .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
      .IRQ(IRQ), .DESC_REQ(DESC_REQ), .DESC_ADDR(DESC_ADDR),
      .DESC_ACK(DESC_ACK), .DESC_CTRL(DESC_CTRL), .DESC_LEN(DESC_LEN),
      .DESC_SRC(DESC_SRC), .DESC_DST(DESC_DST), .DESC_NEXT(DESC_NEXT),
      .DESC_WB(DESC_WB), .DESC_WB_WORD(DESC_WB_WORD), .XFER_REQ(XFER_REQ),
      .XFER_SRC(XFER_SRC), .XFER_DST(XFER_DST), .XFER_SIZE(XFER_SIZE),
      .XFER_ACK(XFER_ACK), .CMD_BUS(CMD_BUS), .CMD_VALID(CMD_VALID),
      .PERIPH_EOF(PERIPH_EOF), .STAT_REQ(STAT_REQ), .STAT_ACK(STAT_ACK),
      .STAT_DATA(STAT_DATA));
   periph_model far (.clk(CLOCK), .rst(RST), .slow(slow),
      .desc_req(DESC_REQ), .desc_ack(DESC_ACK), .xfer_req(XFER_REQ),
      .xfer_ack(XFER_ACK), .stat_req(STAT_REQ), .stat_ack(STAT_ACK),
      .stat_data(STAT_DATA), .stat_val(stat_val));
   // ==========================================================
   // monitor of units, commands, fetches and write-backs
   always @(posedge CLOCK) begin
      if (XFER_REQ & XFER_ACK) begin
         srcs.push_back(XFER_SRC);
         dsts.push_back(XFER_DST);
         sz_seen <= XFER_SIZE;
      end
      if (CMD_VALID) cmd_seen <= CMD_BUS;
      if (DESC_REQ & DESC_ACK) begin
         daq.push_back(DESC_ADDR);
         nd <= nd + 2'h1;
      end
      if (DESC_WB) wbq.push_back(DESC_WB_WORD);
   end
   // ==========================================================
   // helpers
   task automatic check(string what, logic [31:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic apb(logic w, logic [23:0] a, logic [31:0] d);
      @(posedge CLOCK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLOCK);
      PENABLE <= 1'b1;
      // hold the request until ready is sampled
      do @(posedge CLOCK); while (PREADY !== 1'b1);
      rdv = PRDATA;
      err = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask : apb
   task automatic wr(logic [23:0] a, logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   // poll the state register; a hang counts as a mismatch
   task automatic idle();
      repeat (80) begin
         apb(1'b0, ADDR_STATE, 0);
         if (rdv[2:0] === 3'h0) return;
      end
      check("idle", 0, 1);
   endtask : idle
   function automatic logic [1:0] dir(logic [23:0] a, b);
      return (b == a) ? STEP_FIXED : (b > a) ? STEP_INC : STEP_DEC;
   endfunction : dir
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : test_done
   initial begin
      #200000;
      mismatches++;
      test_done();
   end
   // ==========================================================
   // main sequence
   initial begin
      void'($urandom(7097));
      repeat (8) @(posedge CLOCK);
      RST <= 1'b0;
      apb(1'b0, ADDR_CTRL, 0);
      check("ctrl reset", rdv, 0);
      apb(1'b0, 24'hffe47c, 0);
      check("unmapped", err, 1);
      // direct buffers over every legal size and step code
      for (int i = 0; i < 6; i++) begin
         sz = 2'(i % 3);
         ds = 2'((i + 1) % 3);
         ss = 2'((i + 2) % 3);
         cmd = 4'($urandom);
         src = 24'h1000 + 24'($urandom % 256);
         slow = i[1];
         wr(ADDR_MASK, 32'h7);
         wr(ADDR_LEN, 32'h2);
         wr(ADDR_SRC, {8'h0, src});
         wr(ADDR_DST, 32'h8000);
         srcs = {};
         dsts = {};
         wr(ADDR_CTRL, {16'h0, 2'h2, sz, ds, ss, i[0], 3'h0, cmd});
         idle();
         check("cmd", cmd_seen, cmd);
         check("size", sz_seen, sz);
         check("src0", srcs[0], src);
         check("srcstep", dir(srcs[0], srcs[1]), ss);
         check("dststep", dir(dsts[0], dsts[1]), ds);
         apb(1'b0, ADDR_STAT, 0);
         check("buf end", rdv, i[0]);
         check("irq", IRQ, i[0]);
         apb(1'b0, ADDR_CTRL, 0);
         check("enable", rdv[15], 0);
         wr(ADDR_STAT, 32'h7);
      end
      // reserved size code never starts
      srcs = {};
      wr(ADDR_CTRL, 32'h0000b000);
      idle();
      apb(1'b0, ADDR_STAT, 0);
      check("refused", rdv, 4);
      check("irq refused", IRQ, 1);
      check("no units", srcs.size(), 0);
      wr(ADDR_STAT, 32'h7);
      apb(1'b0, ADDR_STAT, 0);
      check("irq off", IRQ, 0);
      // early end of frame from the peripheral
      slow = 1'b1;
      wr(ADDR_LEN, 32'h4);
      wr(ADDR_CTRL, 32'h00008500);
      repeat (50) if (srcs.size() == 0) @(posedge CLOCK);
      PERIPH_EOF <= 1'b1;
      @(posedge CLOCK);
      PERIPH_EOF <= 1'b0;
      idle();
      check("cut", srcs.size() < 4, 1);
      apb(1'b0, ADDR_STAT, 0);
      check("early", rdv, 2);
      check("irq early", IRQ, 1);
      wr(ADDR_STAT, 32'h7);
      // linked list: frame end, jump, halt with loop
      slow = 1'b0;
      stat_val = 4'($urandom);
      PSTRB <= 4'h2;
      wr(ADDR_LIST, 32'h100);
      apb(1'b0, ADDR_STATE, 0);
      check("no start", rdv[2:0], 0);
      PSTRB <= 4'h1;
      wr(ADDR_LIST, 32'h100);
      PSTRB <= 4'hf;
      idle();
      check("fetches", daq.size(), 3);
      check("start", daq[0], 24'h100);
      check("advance", daq[1], 24'h110);
      check("jump", daq[2], DESC_NEXT);
      check("writebacks", wbq.size(), 2);
      check("status", wbq[0][3:0], stat_val);
      check("pass", wbq[1][3:0], dtab[1][3:0]);
      test_done();
   end
endmodule : tb
`default_nettype wire
